// ---- logic/mbp_pkg.sv ----
// shared constants and carrier types for the memory bank and page select block
package mbp_pkg;
  // data-space locations of the write-only selection registers
  localparam logic [7:0] ROM_WIN_ADDR = 8'hc9;
  localparam logic [7:0] PAGE_ADDR = 8'hca;
  localparam logic [7:0] BANK_ADDR = 8'he8;
  // data-space areas
  localparam logic [7:0] BANK_AREA_LO = 8'h00;
  localparam logic [7:0] BANK_AREA_HI = 8'h3f;
  localparam logic [7:0] WIN_AREA_LO = 8'h40;
  localparam logic [7:0] WIN_AREA_HI = 8'h7f;
  // field layout
  localparam int PC_W = 12;
  localparam int PAGE_OFS_W = 11;
  localparam int PAGE_FIELD_W = 5;
  localparam int WIN_OFS_W = 6;
  localparam int BANK_OFS_W = 6;
  localparam int COUNTER_TOP_BIT = 11;
  localparam logic [4:0] STATIC_PAGE = 5'h01;
  localparam int STACK_DEPTH = 6;
  // 16 kbyte reach of the data window: 14 address bits
  localparam int WIN_REACH_W = 14;

  // data-space access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mbp_dspace_s;
endpackage : mbp_pkg

// ---- logic/mbp_sel_reg.sv ----
// write-only selection register with no reset
`timescale 1ns/10ps
module mbp_sel_reg #(
  parameter int W = 8,
  parameter logic [7:0] ADDR = 8'h00
) (
  // clock
  input wire logic i_sys_clk,
  // data-space write
  input wire mbp_pkg::mbp_dspace_s i_acc,
  // held value
  output logic [W-1:0] o_val
);
  // no reset on purpose: content stays undefined until first write
  always_ff @(posedge i_sys_clk) begin
    if (i_acc.wr && i_acc.addr == ADDR) begin
      o_val <= i_acc.wdata[W-1:0];
    end
  end
endmodule : mbp_sel_reg

// ---- logic/mbp_stack.sv ----
// six-level return address stack outside the data space
`timescale 1ns/10ps
module mbp_stack #(
  parameter int DEPTH = mbp_pkg::STACK_DEPTH,
  parameter int W = mbp_pkg::PC_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // push and pop
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [W-1:0] i_push_addr,
  // top of stack
  output logic [W-1:0] o_top
);
  logic [W-1:0] lvl_q [DEPTH];

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
      logic [W-1:0] push_in;
      logic [W-1:0] pop_in;
      // end levels pick their source at elaboration, no out-of-range index
      if (i == 0) begin : g_top
        assign push_in = i_push_addr;
      end else begin : g_mid_push
        assign push_in = lvl_q[i-1];
      end
      if (i == DEPTH - 1) begin : g_bottom
        assign pop_in = lvl_q[i];
      end else begin : g_mid_pop
        assign pop_in = lvl_q[i+1];
      end
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          lvl_q[i] <= '0;
        end else if (i_push) begin
          lvl_q[i] <= push_in;
        end else if (i_pop) begin
          lvl_q[i] <= pop_in;
        end
      end
    end
  endgenerate

  assign o_top = lvl_q[0];
endmodule : mbp_stack

// ---- logic/mbp_bank_page.sv ----
// program page, data bank and rom window selection for the core
`timescale 1ns/10ps

// Overview of operation
// - page register written only at CAh; no bit set or clear on it.
// - page register picks the 2-kbyte rom bank for the lower half.
// - page register has no reset; undefined until first write.
// - interrupts and calls leave the page register untouched.
// - bank register written only at E8h; no bit operations.
// - bank register picks a 64-byte bank for data addresses 00h-3Fh.
// - bank register has no reset; interrupts and calls leave it alone.
// - window register written only at C9h; no bit operations.
// - reads at 40h-7Fh use window bits over six low address bits.
// - program counter is 12 bits; wider rom only through page select.
// - banked rom only for counter 000h-7FFh; upper half is static.
// - counter top bit one picks page 1; else page bits pick page.
// - page 1 below and the static half hit the same rom bytes.
// - top three page bits unused; only needed low page bits kept.
// - stack is six 12-bit return registers outside the data space.
// - data window never reaches rom above 16 kbytes.
module mbp_bank_page #(
  parameter int PAGE_BITS = 4,
  parameter int BANK_BITS = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // core program fetch
  input wire logic [mbp_pkg::PC_W-1:0] i_pc,
  // core data-space access
  input wire mbp_pkg::mbp_dspace_s i_acc,
  // call and return
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [mbp_pkg::PC_W-1:0] i_push_addr,
  // program rom address
  output logic [PAGE_BITS+mbp_pkg::PAGE_OFS_W-1:0] o_prog_addr,
  // banked ram/eeprom access
  output logic o_bank_sel,
  output logic [BANK_BITS+mbp_pkg::BANK_OFS_W-1:0] o_bank_addr,
  // data rom window read
  output logic o_win_rd,
  output logic [mbp_pkg::WIN_REACH_W-1:0] o_win_addr,
  // stack top for return
  output logic [mbp_pkg::PC_W-1:0] o_ret_addr
);
  localparam int WIN_SEL_W = mbp_pkg::WIN_REACH_W - mbp_pkg::WIN_OFS_W;
  localparam int PA_W = PAGE_BITS + mbp_pkg::PAGE_OFS_W;

  logic [PAGE_BITS-1:0] page_val;
  logic [BANK_BITS-1:0] bank_val;
  logic [WIN_SEL_W-1:0] win_val;
  logic [PAGE_BITS-1:0] page_eff;
  logic [PA_W-1:0] prog_addr_d;
  logic [PA_W-1:0] prog_addr_q;
  logic bank_sel_q;
  logic [BANK_BITS+mbp_pkg::BANK_OFS_W-1:0] bank_addr_q;
  logic win_rd_q;
  logic [mbp_pkg::WIN_REACH_W-1:0] win_addr_q;
  logic [mbp_pkg::PC_W-1:0] ret_top;
  logic [mbp_pkg::PC_W-1:0] ret_q;
  logic in_bank;
  logic in_win;

  // page select register, only low page bits kept
  mbp_sel_reg #(
    .W(PAGE_BITS),
    .ADDR(mbp_pkg::PAGE_ADDR)
  ) u_page (
    .i_sys_clk(i_sys_clk),
    .i_acc(i_acc),
    .o_val(page_val)
  );

  // data bank select register
  mbp_sel_reg #(
    .W(BANK_BITS),
    .ADDR(mbp_pkg::BANK_ADDR)
  ) u_bank (
    .i_sys_clk(i_sys_clk),
    .i_acc(i_acc),
    .o_val(bank_val)
  );

  // rom window register, truncated to the 16 kbyte reach
  mbp_sel_reg #(
    .W(WIN_SEL_W),
    .ADDR(mbp_pkg::ROM_WIN_ADDR)
  ) u_win (
    .i_sys_clk(i_sys_clk),
    .i_acc(i_acc),
    .o_val(win_val)
  );

  // return stack, separate from the data space
  mbp_stack u_stack (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_push(i_push),
    .i_pop(i_pop),
    .i_push_addr(i_push_addr),
    .o_top(ret_top)
  );

  // page mapping: upper half always static page
  always_comb begin
    if (i_pc[mbp_pkg::COUNTER_TOP_BIT]) begin
      page_eff = mbp_pkg::STATIC_PAGE[PAGE_BITS-1:0];
    end else begin
      page_eff = page_val;
    end
    prog_addr_d = {page_eff, i_pc[mbp_pkg::PAGE_OFS_W-1:0]};
  end

  assign in_bank = i_acc.addr <= mbp_pkg::BANK_AREA_HI;
  assign in_win = (i_acc.addr >= mbp_pkg::WIN_AREA_LO) && (i_acc.addr <= mbp_pkg::WIN_AREA_HI);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prog_addr_q <= '0;
    end else begin
      prog_addr_q <= prog_addr_d;
    end
  end

  // banked ram/eeprom decode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bank_sel_q <= 1'b0;
      bank_addr_q <= '0;
    end else begin
      bank_sel_q <= (i_acc.rd || i_acc.wr) && in_bank;
      bank_addr_q <= {bank_val, i_acc.addr[mbp_pkg::BANK_OFS_W-1:0]};
    end
  end

  // data rom window read
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win_rd_q <= 1'b0;
      win_addr_q <= '0;
    end else begin
      win_rd_q <= i_acc.rd && in_win;
      win_addr_q <= {win_val, i_acc.addr[mbp_pkg::WIN_OFS_W-1:0]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ret_q <= '0;
    end else begin
      ret_q <= ret_top;
    end
  end

  assign o_prog_addr = prog_addr_q;
  assign o_bank_sel = bank_sel_q;
  assign o_bank_addr = bank_addr_q;
  assign o_win_rd = win_rd_q;
  assign o_win_addr = win_addr_q;
  assign o_ret_addr = ret_q;
endmodule : mbp_bank_page

// ---- bench/mbp_bank_page_props.sv ----
// bank and page select port assertions
`timescale 1ns/10ps
module mbp_bank_page_props #(
  parameter int PAGE_BITS = 4,
  parameter int BANK_BITS = 4
) (
  input logic i_sys_clk,
  input logic i_nrst,
  input logic [11:0] i_pc,
  input mbp_pkg::mbp_dspace_s i_acc,
  input logic i_push,
  input logic i_pop,
  input logic [11:0] i_push_addr,
  input logic [PAGE_BITS+10:0] o_prog_addr,
  input logic o_bank_sel,
  input logic [BANK_BITS+5:0] o_bank_addr,
  input logic o_win_rd,
  input logic [13:0] o_win_addr,
  input logic [11:0] o_ret_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire win = i_acc.rd && i_acc.addr[7:6] == 2'b01;
  wire bank = (i_acc.rd || i_acc.wr) && i_acc.addr[7:6] == 2'b00;
  wire pg_wr = i_acc.wr && i_acc.addr == mbp_pkg::PAGE_ADDR;
  sequence s_push; i_push ##1 !i_push && !i_pop; endsequence
  sequence s_low; !i_pc[11] && !pg_wr ##1 !i_pc[11]; endsequence
  property p_static; i_pc[11] |=> o_prog_addr == {PAGE_BITS'(1), $past(i_pc[10:0])}; endproperty
  property p_low; !i_pc[11] |=> o_prog_addr[10:0] == $past(i_pc[10:0]); endproperty
  property p_hold; s_low |=> $stable(o_prog_addr[PAGE_BITS+10:11]); endproperty
  property p_win; win |=> o_win_rd && o_win_addr[5:0] == $past(i_acc.addr[5:0]); endproperty
  property p_win_only; !win |=> !o_win_rd; endproperty
  property p_bank; bank |=> o_bank_sel && o_bank_addr[5:0] == $past(i_acc.addr[5:0]); endproperty
  property p_bank_only; !bank |=> !o_bank_sel; endproperty
  property p_ret; s_push |=> o_ret_addr == $past(i_push_addr, 2); endproperty
  a_static: assert property (p_static) else $error("static page");
  a_low: assert property (p_low) else $error("low offset");
  a_hold: assert property (p_hold) else $error("page moved");
  a_win: assert property (p_win) else $error("window read");
  a_win_only: assert property (p_win_only) else $error("stray window");
  a_bank: assert property (p_bank) else $error("bank access");
  a_bank_only: assert property (p_bank_only) else $error("stray bank");
  a_ret: assert property (p_ret) else $error("return address");
endmodule : mbp_bank_page_props
bind mbp_bank_page mbp_bank_page_props #(.PAGE_BITS(PAGE_BITS), .BANK_BITS(BANK_BITS)) i_props (.*);

// ---- bench/mbp_core_model.sv ----
// core side: fetches, data-space accesses and calls
`timescale 1ns/10ps
module mbp_core_model (
  // clock
  input logic i_sys_clk,
  // core requests
  output logic [11:0] o_pc,
  output mbp_pkg::mbp_dspace_s o_acc,
  output logic o_push,
  output logic [11:0] o_push_addr,
  output logic o_fetch
);
  initial begin
    o_pc = 12'h800;
    o_acc = '0;
    o_push = 1'b0;
    o_push_addr = '0;
    o_fetch = 1'b0;
  end
  // kind 0 fetch, 1 write, 2 read, 3 call
  task automatic op(input logic [1:0] k, input logic [7:0] ad, input logic [11:0] v);
    @(posedge i_sys_clk);
    #1;
    if (k == 2'd0) o_pc = v;
    o_fetch = k == 2'd0;
    o_acc = {k == 2'd1, k == 2'd2, ad, v[7:0]};
    o_push = k == 2'd3;
    o_push_addr = v;
    @(posedge i_sys_clk);
    #1;
    o_acc = {2'b00, ~ad, ~v[7:0]};
    o_fetch = 1'b0;
    o_push = 1'b0;
  endtask : op
endmodule : mbp_core_model

// ---- bench/tb_top.sv ----
// self-checking bench for bank and page select
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_pop = 1'b0;
  logic i_push, fetch, fetch_q = 1'b0, o_bank_sel, o_win_rd;
  logic [11:0] i_pc, i_push_addr, o_ret_addr, r, s;
  mbp_pkg::mbp_dspace_s i_acc;
  logic [14:0] o_prog_addr;
  logic [9:0] o_bank_addr;
  logic [13:0] o_win_addr;
  logic [16:0] seen;
  logic [16:0] exp_q[$];
  logic [5:0] a;
  int failures = 0, compares = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  mbp_core_model i_mbp_core_model (.i_sys_clk, .o_pc(i_pc), .o_acc(i_acc), .o_push(i_push),
    .o_push_addr(i_push_addr), .o_fetch(fetch));
  mbp_bank_page i_mbp_bank_page (.i_sys_clk, .i_nrst, .i_pc, .i_acc, .i_push, .i_pop,
    .i_push_addr, .o_prog_addr, .o_bank_sel, .o_bank_addr, .o_win_rd, .o_win_addr, .o_ret_addr);
  task automatic check(input logic [16:0] got, input logic [16:0] want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic op(input logic [1:0] k, input logic [7:0] ad, input logic [11:0] v);
    i_mbp_core_model.op(k, ad, v);
  endtask : op
  task automatic note(input logic [1:0] k, input logic [14:0] v);
    exp_q.push_back({k, v});
  endtask : note
  always @(posedge i_sys_clk) fetch_q <= fetch;
  always @(negedge i_sys_clk) begin
    if ((fetch_q | o_win_rd | o_bank_sel) === 1'b1) begin
      seen = fetch_q ? {2'd0, o_prog_addr} : o_win_rd ? {3'd2, o_win_addr} : {7'h40, o_bank_addr};
      check(seen, exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff);
    end
  end
  // a run-away counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h4d42199e));
    repeat (4) @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    for (int p = 0; p < 10; p++) begin
      s = r;
      r = 12'($urandom);
      op(2'd1, 8'h90, 12'(p));
      op(2'd1, 8'hca, {r[11:4], 4'(p)});
      op(2'd2, 8'hca, 12'h0);
      op(2'd3, 8'h00, r);
      op(2'd1, 8'hcb, r);
      check({5'd0, o_ret_addr}, {5'd0, r});
      note(2'd0, {4'(p), r[10:0]});
      op(2'd0, 8'h00, {1'b0, r[10:0]});
      note(2'd0, {4'h1, r[10:0]});
      op(2'd0, 8'h00, {1'b1, r[10:0]});
      $display("page %0d done", p);
    end
    @(posedge i_sys_clk);
    #1 i_pop = 1'b1;
    @(posedge i_sys_clk);
    #1 i_pop = 1'b0;
    @(posedge i_sys_clk);
    #1 check({5'd0, o_ret_addr}, {5'd0, s});
    for (int i = 0; i < 8; i++) begin
      r = 12'($urandom);
      a = 6'($urandom);
      op(2'd1, 8'hc9, r);
      op(2'd1, 8'he8, {4'h0, r[11:4]});
      op(2'd1, {2'b01, a}, 12'h0);
      note(2'd1, {1'b0, r[7:0], a});
      op(2'd2, {2'b01, a}, 12'h0);
      note(2'd2, {5'd0, r[7:4], a});
      op(i[0] ? 2'd1 : 2'd2, {2'b00, a}, 12'h0);
    end
    $display("window and bank done");
    @(posedge i_sys_clk);
    #1 i_nrst = 1'b0;
    @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    note(2'd0, {4'h9, 11'h123});
    op(2'd0, 8'h00, 12'h123);
    note(2'd0, {4'h1, 11'h000});
    op(2'd0, 8'h00, 12'h800);
    note(2'd2, {5'd0, r[7:4], a});
    op(2'd2, {2'b00, a}, 12'h0);
    @(posedge i_sys_clk);
    check(17'(exp_q.size()), 17'h0);
    $display("reset hold done");
    tally_and_finish();
  end
endmodule : tb_top
